/* File: hdl/ddrf_params.svh */
// Purpose: Shared constants of the read, flag and strap control block
// Assumes: Included by bare name from the strap sync, word store and control files
// Notes: Offsets are in whole 40-bit words
`ifndef DDRF_PARAMS_SVH
`define DDRF_PARAMS_SVH

`define DDRF_DATA_W 40
`define DDRF_DEPTH 16

// Strap vector bit positions
`define DDRF_STRAP_N 7
`define DDRF_STRAP_FSEL_LO 0
`define DDRF_STRAP_FSEL_HI 1
`define DDRF_STRAP_FALL 2
`define DDRF_STRAP_IN_W 3
`define DDRF_STRAP_OUT_W 4
`define DDRF_STRAP_MATCH 5
`define DDRF_STRAP_DDR 6

// Four preset default offsets, empty side n and full side m
`define DDRF_EMPTY_DEF0 8'h01
`define DDRF_EMPTY_DEF1 8'h02
`define DDRF_EMPTY_DEF2 8'h04
`define DDRF_EMPTY_DEF3 8'h08
`define DDRF_FULL_DEF0 8'h01
`define DDRF_FULL_DEF1 8'h02
`define DDRF_FULL_DEF2 8'h04
`define DDRF_FULL_DEF3 8'h08

`endif

/* File: hdl/ddrf_pkg.sv */
// Purpose: Types of the read, flag and strap control block
// Assumes: Nothing
// Notes: Constants live in ddrf_params.svh
package ddrf_pkg;

   typedef enum logic [2:0] {
      ddrf_w40_40,
      ddrf_w40_20,
      ddrf_w40_10,
      ddrf_w20_40,
      ddrf_w10_40
   } ddrf_width_mode_t;

   typedef enum {
      ddrf_out_empty,
      ddrf_out_held
   } ddrf_out_state_t;

endpackage

/* File: hdl/ddrf_fifo_if.sv */
// Purpose: Carrier between the control logic and the word store
// Assumes: One clock on both sides
// Notes: Count is in stored words
`timescale 1ns/1ps
`default_nettype none
interface ddrf_fifo_if #(parameter int W = 40, parameter int D = 16);
   logic push_valid;
   logic push_ready;
   logic [W-1:0] push_data;
   logic pop_valid;
   logic pop_ready;
   logic [W-1:0] pop_data;
   logic clear;
   logic mark;
   logic rewind;
   logic [$clog2(D):0] count;
   modport store (input push_valid, push_data, pop_ready, clear, mark, rewind,
                  output push_ready, pop_valid, pop_data, count);
   modport user (output push_valid, push_data, pop_ready, clear, mark, rewind,
                 input push_ready, pop_valid, pop_data, count);
endinterface
`default_nettype wire

/* File: hdl/ddrf_strap_sync.sv */
// Purpose: Two-flop synchroniser for the configuration strap pins
// Assumes: Straps are quasi-static levels
// Notes: Only the second stage is read outside
`timescale 1ns/1ps
`default_nettype none
`include "ddrf_params.svh"
module ddrf_strap_sync #(
   parameter int N = `DDRF_STRAP_N
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [N-1:0] pin_in,
   output logic [N-1:0] pin_sync
);
   logic [N-1:0] meta_reg;

   always_ff @(posedge clk) begin
      if (rst) begin
         meta_reg <= '0;
         pin_sync <= '0;
      end else begin
         meta_reg <= pin_in;
         pin_sync <= meta_reg;
      end
   end
endmodule // ddrf_strap_sync
`default_nettype wire

/* File: hdl/ddrf_fifo.sv */
// Purpose: Word store with mark and rewind, registered head word
// Assumes: Depth is a power of two
// Notes: Rewind is only meaningful while marked words are not overwritten
`timescale 1ns/1ps
`default_nettype none
`include "ddrf_params.svh"
module ddrf_fifo #(
   parameter int WIDTH = `DDRF_DATA_W,
   parameter int DEPTH = `DDRF_DEPTH
) (
   input wire logic clk,
   input wire logic rst,
   ddrf_fifo_if.store bus
);
   localparam int AW = $clog2(DEPTH);

   generate
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
         $error("ddrf_fifo: DEPTH must be a power of two of at least 2");
      end
   endgenerate

   logic [WIDTH-1:0] mem [DEPTH];
   logic [WIDTH-1:0] head_reg;
   logic [AW-1:0] wr_ptr_reg;
   logic [AW-1:0] rd_ptr_reg;
   logic [AW-1:0] mark_reg;
   logic [AW-1:0] rd_ptr_next;
   logic [AW-1:0] rewind_gap;
   logic [AW:0] count_reg;
   logic push;
   logic pop;

   assign push = bus.push_valid && bus.push_ready && !bus.clear;
   assign pop = bus.pop_ready && bus.pop_valid && !bus.rewind && !bus.clear;
   assign bus.push_ready = count_reg != (AW+1)'(DEPTH);
   assign bus.pop_valid = count_reg != '0;
   assign bus.pop_data = head_reg;
   assign bus.count = count_reg;
   assign rewind_gap = rd_ptr_reg - mark_reg;

   always_comb begin
      if (bus.clear) begin
         rd_ptr_next = '0;
      end else if (bus.rewind) begin
         rd_ptr_next = mark_reg;
      end else begin
         rd_ptr_next = rd_ptr_reg + AW'(pop);
      end
   end

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr_reg] <= bus.push_data;
      end
   end

   // Head word read ahead, bypassing a write to the same slot
   always_ff @(posedge clk) begin
      if (push && wr_ptr_reg == rd_ptr_next) begin
         head_reg <= bus.push_data;
      end else begin
         head_reg <= mem[rd_ptr_next];
      end
   end

   always_ff @(posedge clk) begin
      if (rst || bus.clear) begin
         wr_ptr_reg <= '0;
      end else if (push) begin
         wr_ptr_reg <= wr_ptr_reg + AW'(1);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rd_ptr_reg <= '0;
      end else begin
         rd_ptr_reg <= rd_ptr_next;
      end
   end

   always_ff @(posedge clk) begin
      if (rst || bus.clear) begin
         mark_reg <= '0;
      end else if (bus.mark) begin
         mark_reg <= rd_ptr_reg;
      end
   end

   always_ff @(posedge clk) begin
      if (rst || bus.clear) begin
         count_reg <= '0;
      end else if (bus.rewind) begin
         count_reg <= count_reg + {1'b0, rewind_gap} + (AW+1)'(push);
      end else begin
         count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule // ddrf_fifo
`default_nettype wire

/* File: hdl/ddrf_read_flag_ctrl.sv */
// Purpose: Read port, resets, flags and straps of a 40-bit SDR/DDR FIFO
// Assumes: ref_clk is the read clock; host logic shares it
// Notes: A falling read edge is modelled as the odd ref_clk phase
//
// Operation
// R1 - Flag-select straps pick one of four offsets
// R2 - Fall-through strap latched; forced off under DDR
// R3 - Fall-through shows first word without read request
// R4 - Width straps latched at full reset
// R5 - Mark records read pointer for retransmit
// R6 - Only the latest mark is kept
// R7 - Full reset clears pointers, output, reloads straps
// R8 - Pointer reset clears pointers, keeps configuration
// R9 - Output enable high floats data, nothing else
// R10 - Almost-empty high when count at least n
// R11 - Almost-full high when free exceeds m
// R12 - DDR reads both edges, SDR rising only
// R13 - Read select gates port and drive synchronously
// R14 - Read select ignored during resets
// R15 - DDR read moves word into output register
// R16 - SDR reads only on rising edges
// R17 - Width strap low gives 40/40, else table
// R18 - Retransmit rewinds to mark, else location zero
// R19 - Almost-empty on rising read edge only
`timescale 1ns/1ps
`default_nettype none
`include "ddrf_params.svh"
module ddrf_read_flag_ctrl #(
   parameter int DATA_W = `DDRF_DATA_W,
   parameter int DEPTH = `DDRF_DEPTH
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic full_reset_n,
   input wire logic pointer_only_reset_n,
   input wire logic flag_default_select_lo,
   input wire logic flag_default_select_hi,
   input wire logic fall_through_timing_sel,
   input wire logic input_width_strap,
   input wire logic output_width_strap,
   input wire logic width_matching_strap,
   input wire logic read_ddr_strap,
   input wire logic [DATA_W-1:0] write_data,
   input wire logic write_valid,
   output logic write_ready,
   input wire logic read_enable_n,
   input wire logic read_port_select_n,
   input wire logic output_enable_n,
   input wire logic mark_read_pos,
   input wire logic retransmit_n,
   output logic [DATA_W-1:0] read_data_out,
   output logic read_data_oe,
   output logic status_flag_n,
   output logic almost_empty_n,
   output logic almost_full_n,
   output logic read_rise_phase,
   output logic fall_through_active,
   output logic read_ddr_active
);
   localparam int CW = $clog2(DEPTH) + 1;

   generate
      if (DATA_W % 4 != 0 || DATA_W < 4) begin : g_bad_width
         $error("ddrf_read_flag_ctrl: DATA_W must be a multiple of 4");
      end
      if (DEPTH < 4) begin : g_bad_depth
         $error("ddrf_read_flag_ctrl: DEPTH must be at least 4");
      end
   endgenerate

   ddrf_fifo_if #(.W(DATA_W), .D(DEPTH)) fifo_bus ();

   logic [`DDRF_STRAP_N-1:0] strap_raw;
   logic [`DDRF_STRAP_N-1:0] strap_sync;
   ddrf_pkg::ddrf_width_mode_t mode_reg;
   ddrf_pkg::ddrf_width_mode_t mode_next;
   ddrf_pkg::ddrf_out_state_t out_state_reg;
   logic reset_full;
   logic reset_any;
   logic [CW-1:0] empty_off_reg;
   logic [CW-1:0] full_off_reg;
   logic [CW-1:0] empty_off_next;
   logic [CW-1:0] full_off_next;
   logic [1:0] wr_sub_reg;
   logic [1:0] wr_last;
   logic [1:0] wr_shift;
   logic [1:0] rd_sub_reg;
   logic [1:0] rd_last;
   logic [1:0] rd_shift;
   logic [DATA_W-1:0] acc_reg;
   logic [DATA_W-1:0] acc_next;
   logic [DATA_W-1:0] wr_slice;
   logic [DATA_W-1:0] rd_slice;
   logic wr_fire;
   logic rd_sel_off_reg;
   logic rise_edge;
   logic read_edge;
   logic take;
   logic drop;
   logic rewind_evt;
   logic mark_evt;

   assign strap_raw = {read_ddr_strap, width_matching_strap, output_width_strap, input_width_strap,
                       fall_through_timing_sel, flag_default_select_hi, flag_default_select_lo};

   ddrf_strap_sync #(.N(`DDRF_STRAP_N)) u_strap_sync (
      .clk(ref_clk),
      .rst(rst),
      .pin_in(strap_raw),
      .pin_sync(strap_sync)
   );

   ddrf_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) u_store (
      .clk(ref_clk),
      .rst(rst),
      .bus(fifo_bus)
   );

   assign reset_full = rst || !full_reset_n;
   assign reset_any = reset_full || !pointer_only_reset_n;

   // Strap decode for width and default offsets
   always_comb begin
      if (!strap_sync[`DDRF_STRAP_MATCH]) begin
         mode_next = ddrf_pkg::ddrf_w40_40; // R17
      end else begin
         case ({strap_sync[`DDRF_STRAP_IN_W], strap_sync[`DDRF_STRAP_OUT_W]})
            2'h0: mode_next = ddrf_pkg::ddrf_w40_20; // R17
            2'h1: mode_next = ddrf_pkg::ddrf_w40_10;
            2'h2: mode_next = ddrf_pkg::ddrf_w20_40;
            2'h3: mode_next = ddrf_pkg::ddrf_w10_40;
            default: mode_next = ddrf_pkg::ddrf_w40_40;
         endcase
      end
      case ({strap_sync[`DDRF_STRAP_FSEL_HI], strap_sync[`DDRF_STRAP_FSEL_LO]})
         2'h0: begin
            empty_off_next = CW'(`DDRF_EMPTY_DEF0); // R1
            full_off_next = CW'(`DDRF_FULL_DEF0);
         end
         2'h1: begin
            empty_off_next = CW'(`DDRF_EMPTY_DEF1);
            full_off_next = CW'(`DDRF_FULL_DEF1);
         end
         2'h2: begin
            empty_off_next = CW'(`DDRF_EMPTY_DEF2);
            full_off_next = CW'(`DDRF_FULL_DEF2);
         end
         default: begin
            empty_off_next = CW'(`DDRF_EMPTY_DEF3);
            full_off_next = CW'(`DDRF_FULL_DEF3);
         end
      endcase
   end

   // Configuration follows straps only while full reset holds
   always_ff @(posedge ref_clk) begin
      if (reset_full) begin
         mode_reg <= mode_next; // R4
         read_ddr_active <= strap_sync[`DDRF_STRAP_DDR];
         fall_through_active <= strap_sync[`DDRF_STRAP_FALL] && !strap_sync[`DDRF_STRAP_DDR]; // R2
         empty_off_reg <= empty_off_next; // R7
         full_off_reg <= full_off_next; // R8
      end
   end

   // Slice counts and shifts per port width
   always_comb begin
      wr_last = 2'h0;
      wr_shift = 2'h0;
      rd_last = 2'h0;
      rd_shift = 2'h0;
      case (mode_reg)
         ddrf_pkg::ddrf_w40_20: begin
            rd_last = 2'h1;
            rd_shift = 2'h1;
         end
         ddrf_pkg::ddrf_w40_10: begin
            rd_last = 2'h3;
            rd_shift = 2'h2;
         end
         ddrf_pkg::ddrf_w20_40: begin
            wr_last = 2'h1;
            wr_shift = 2'h1;
         end
         ddrf_pkg::ddrf_w10_40: begin
            wr_last = 2'h3;
            wr_shift = 2'h2;
         end
         default: begin
            wr_last = 2'h0;
            rd_last = 2'h0;
         end
      endcase
   end

   // Write side packs narrow slices low first
   assign wr_fire = write_valid && write_ready && !reset_any;
   assign wr_slice = (write_data & ({DATA_W{1'b1}} >> (DATA_W - (DATA_W >> wr_shift))))
                     << (wr_sub_reg * (DATA_W >> wr_shift));
   assign acc_next = acc_reg | wr_slice;
   assign fifo_bus.push_valid = wr_fire && wr_sub_reg == wr_last;
   assign fifo_bus.push_data = acc_next;

   always_ff @(posedge ref_clk) begin
      if (reset_any) begin
         acc_reg <= '0;
         wr_sub_reg <= 2'h0;
      end else if (wr_fire) begin
         if (wr_sub_reg == wr_last) begin
            acc_reg <= '0;
            wr_sub_reg <= 2'h0;
         end else begin
            acc_reg <= acc_next;
            wr_sub_reg <= wr_sub_reg + 2'h1;
         end
      end
   end

   // Ready leaves room for the one push already under way
   always_ff @(posedge ref_clk) begin
      if (reset_any) begin
         write_ready <= 1'b0;
      end else begin
         write_ready <= fifo_bus.count <= CW'(DEPTH - 2);
      end
   end

   // Rising and falling read edges alternate on ref_clk
   always_ff @(posedge ref_clk) begin
      if (reset_any) begin
         read_rise_phase <= 1'b1;
      end else begin
         read_rise_phase <= !read_rise_phase;
      end
   end

   assign rise_edge = read_rise_phase;
   assign read_edge = rise_edge || read_ddr_active; // R12 R16

   always_ff @(posedge ref_clk) begin
      rd_sel_off_reg <= read_port_select_n; // R13
   end

   assign rewind_evt = !reset_any && rise_edge && !retransmit_n; // R18
   assign mark_evt = !reset_any && rise_edge && mark_read_pos && !rewind_evt; // R5 R6
   assign fifo_bus.clear = reset_any; // R7 R8
   assign fifo_bus.mark = mark_evt;
   assign fifo_bus.rewind = rewind_evt;

   // Read decision for this edge
   always_comb begin
      take = 1'b0;
      drop = 1'b0;
      if (!reset_any && !rd_sel_off_reg && read_edge && !rewind_evt) begin // R13 R14
         if (fall_through_active) begin
            if (out_state_reg == ddrf_pkg::ddrf_out_empty || !read_enable_n) begin
               take = fifo_bus.pop_valid; // R3
               drop = !fifo_bus.pop_valid && !read_enable_n;
            end
         end else begin
            take = !read_enable_n && fifo_bus.pop_valid; // R15 R16
         end
      end
   end

   assign fifo_bus.pop_ready = take && rd_sub_reg == rd_last;
   assign rd_slice = (fifo_bus.pop_data >> (rd_sub_reg * (DATA_W >> rd_shift)))
                     & ({DATA_W{1'b1}} >> (DATA_W - (DATA_W >> rd_shift)));

   // Output register
   always_ff @(posedge ref_clk) begin
      if (reset_any) begin
         read_data_out <= '0; // R7 R8
      end else if (take) begin
         read_data_out <= rd_slice; // R15
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset_any) begin
         rd_sub_reg <= 2'h0;
      end else if (rewind_evt) begin
         rd_sub_reg <= 2'h0; // R18
      end else if (take) begin
         rd_sub_reg <= (rd_sub_reg == rd_last) ? 2'h0 : rd_sub_reg + 2'h1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset_any) begin
         out_state_reg <= ddrf_pkg::ddrf_out_empty;
      end else begin
         case (out_state_reg)
            ddrf_pkg::ddrf_out_empty: begin
               if (take) begin
                  out_state_reg <= ddrf_pkg::ddrf_out_held;
               end
            end
            ddrf_pkg::ddrf_out_held: begin
               if ((rewind_evt && fall_through_active) || drop) begin
                  out_state_reg <= ddrf_pkg::ddrf_out_empty;
               end
            end
            default: out_state_reg <= ddrf_pkg::ddrf_out_empty;
         endcase
      end
   end

   // Empty flag in standard timing, output-ready in fall-through
   always_ff @(posedge ref_clk) begin
      if (reset_any) begin
         status_flag_n <= fall_through_active;
      end else if (fall_through_active) begin
         status_flag_n <= out_state_reg != ddrf_pkg::ddrf_out_held;
      end else begin
         status_flag_n <= fifo_bus.pop_valid;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset_any) begin
         almost_empty_n <= 1'b0;
      end else if (rise_edge) begin
         almost_empty_n <= fifo_bus.count >= empty_off_reg; // R10 R19
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset_any) begin
         almost_full_n <= 1'b1;
      end else begin
         almost_full_n <= (CW'(DEPTH) - fifo_bus.count) > full_off_reg; // R11
      end
   end

   // Drive follows output enable; read select counts only outside reset
   always_ff @(posedge ref_clk) begin
      read_data_oe <= !output_enable_n && (reset_any || !read_port_select_n); // R9 R13 R14
   end
endmodule // ddrf_read_flag_ctrl
`default_nettype wire

/* File: dv/ddrf_ctrl_monitor.sv */
// Purpose: Port checker of the read, flag and strap control block
// Assumes: Bound to ddrf_read_flag_ctrl, one clock domain
// Notes: Output enable path has one cycle of latency
`timescale 1ns/1ps
`default_nettype none
module ddrf_ctrl_monitor #(
   parameter int DATA_W = 40
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic full_reset_n,
   input wire logic pointer_only_reset_n,
   input wire logic output_enable_n,
   input wire logic read_port_select_n,
   input wire logic [DATA_W-1:0] read_data_out,
   input wire logic read_data_oe,
   input wire logic almost_empty_n,
   input wire logic almost_full_n,
   input wire logic write_ready,
   input wire logic read_rise_phase,
   input wire logic fall_through_active,
   input wire logic read_ddr_active
);
   logic quiet;
   assign quiet = !rst && full_reset_n && pointer_only_reset_n;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   sequence any_reset_s;
      !full_reset_n || !pointer_only_reset_n;
   endsequence
   sequence cleared_s;
      read_data_out == '0 && !almost_empty_n && almost_full_n && !write_ready;
   endsequence
   oe_float_a: assert property (output_enable_n |=> !read_data_oe)
      else $error("data driven with output enable high");
   sel_drive_a: assert property (!output_enable_n && !read_port_select_n |=> read_data_oe)
      else $error("data not driven while selected");
   sel_float_a: assert property (quiet && read_port_select_n |=> !read_data_oe)
      else $error("data driven while deselected");
   rst_drive_a: assert property (any_reset_s ##0 !output_enable_n |=> read_data_oe)
      else $error("data not driven during reset");
   rst_clear_a: assert property (any_reset_s |=> cleared_s)
      else $error("reset did not clear outputs");
   ptr_keep_a: assert property (full_reset_n && !pointer_only_reset_n
      |=> $stable(fall_through_active) && $stable(read_ddr_active))
      else $error("pointer reset changed configuration");
   ft_ddr_a: assert property (read_ddr_active |-> !fall_through_active)
      else $error("fall through active in double rate");
   sdr_rise_a: assert property ($changed(read_data_out) && !read_ddr_active && $past(quiet)
      |-> $past(read_rise_phase))
      else $error("single rate data moved off rising phase");
   ae_rise_a: assert property ($changed(almost_empty_n) && $past(quiet) |-> $past(read_rise_phase))
      else $error("almost empty moved off rising phase");
endmodule // ddrf_ctrl_monitor
bind ddrf_read_flag_ctrl ddrf_ctrl_monitor #(.DATA_W(DATA_W)) mon (.ref_clk, .rst, .full_reset_n,
   .pointer_only_reset_n, .output_enable_n, .read_port_select_n, .read_data_out, .read_data_oe,
   .almost_empty_n, .almost_full_n, .write_ready, .read_rise_phase, .fall_through_active,
   .read_ddr_active);
`default_nettype wire

/* File: dv/ddrf_host_model.sv */
// Purpose: Host read logic on the read clock
// Assumes: Shares ref_clk with the block
// Notes: Pins change at the falling edge only
`timescale 1ns/1ps
`default_nettype none
module ddrf_host_model (
   input wire logic ref_clk,
   input wire logic want,
   input wire logic use_sel,
   input wire logic hiz_req,
   input wire logic read_rise_phase,
   input wire logic read_ddr_active,
   output logic read_enable_n,
   output logic read_port_select_n,
   output logic output_enable_n
);
   logic want_q;
   initial begin
      want_q = 1'h0;
      read_enable_n = 1'h1;
      read_port_select_n = 1'h0;
      output_enable_n = 1'h0;
   end
   always @(posedge ref_clk) want_q <= want;
   always @(negedge ref_clk) begin
      read_enable_n <= !(want_q && (read_ddr_active || read_rise_phase));
      read_port_select_n <= !use_sel;
      // Output enable may float only while select is unused
      output_enable_n <= hiz_req && !use_sel;
   end
endmodule // ddrf_host_model
`default_nettype wire

/* File: dv/ddr_sdr_fifo_read_flag_control_tb.sv */
// Purpose: Self-checking bench of the read, flag and strap control block
// Assumes: Host pins come from ddrf_host_model
// Notes: Inputs change at the falling edge
`timescale 1ns/1ps
`default_nettype none
module ddr_sdr_fifo_read_flag_control_tb;
   typedef struct packed {logic [1:0] sel; logic [4:0] nw; logic ae; logic af;} ddrf_row_t;
   ddrf_row_t rows [7] = '{'{2'h0, 5'h00, 1'h0, 1'h1}, '{2'h0, 5'h01, 1'h1, 1'h1},
      '{2'h1, 5'h01, 1'h0, 1'h1}, '{2'h2, 5'h04, 1'h1, 1'h1}, '{2'h2, 5'h0C, 1'h1, 1'h0},
      '{2'h3, 5'h07, 1'h0, 1'h1}, '{2'h3, 5'h08, 1'h1, 1'h0}};
   logic ref_clk = 1'h0;
   logic rst = 1'h1;
   logic full_reset_n = 1'h0;
   logic pointer_only_reset_n = 1'h1;
   logic [6:0] strap = 7'h00;
   logic [39:0] write_data = 40'h0;
   logic write_valid = 1'h0;
   logic mark_read_pos = 1'h0;
   logic retransmit_n = 1'h1;
   logic want = 1'h0;
   logic use_sel = 1'h1;
   logic hiz_req = 1'h0;
   wire logic read_enable_n, read_port_select_n, output_enable_n, write_ready, read_data_oe;
   wire logic status_flag_n, almost_empty_n, almost_full_n, read_rise_phase;
   wire logic fall_through_active, read_ddr_active;
   wire logic [39:0] read_data_out;
   int errors = 0;
   int total_checks = 0;
   int cycles = 0;
   always #2 ref_clk = ~ref_clk;
   ddrf_read_flag_ctrl #(.DATA_W(40), .DEPTH(16)) DUT (
      .ref_clk, .rst, .full_reset_n, .pointer_only_reset_n,
      .flag_default_select_lo(strap[0]), .flag_default_select_hi(strap[1]),
      .fall_through_timing_sel(strap[2]), .input_width_strap(strap[3]),
      .output_width_strap(strap[4]), .width_matching_strap(strap[5]), .read_ddr_strap(strap[6]),
      .write_data, .write_valid, .write_ready, .read_enable_n, .read_port_select_n,
      .output_enable_n, .mark_read_pos, .retransmit_n, .read_data_out, .read_data_oe,
      .status_flag_n, .almost_empty_n, .almost_full_n, .read_rise_phase,
      .fall_through_active, .read_ddr_active);
   ddrf_host_model host (.ref_clk, .want, .use_sel, .hiz_req, .read_rise_phase, .read_ddr_active,
      .read_enable_n, .read_port_select_n, .output_enable_n);
   task automatic conclude();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [39:0] exp, input logic [39:0] got);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic cfg(input logic [6:0] s);
      @(negedge ref_clk);
      strap = s;
      full_reset_n = 1'h0;
      repeat (5) @(negedge ref_clk);
      full_reset_n = 1'h1;
      repeat (2) @(negedge ref_clk);
   endtask
   // Valid stays up between calls for back-to-back writes
   task automatic wr(input logic [39:0] d);
      int n;
      n = 0;
      write_valid = 1'h1;
      write_data = d;
      while (write_ready !== 1'h1 && n < 50) begin
         @(negedge ref_clk);
         n++;
      end
      @(negedge ref_clk);
   endtask
   // Two cycles of want give one single-rate or two double-rate reads
   task automatic rdchk(input logic [39:0] exp);
      want = 1'h1;
      repeat (2) @(negedge ref_clk);
      want = 1'h0;
      repeat (3) @(negedge ref_clk);
      chk("read_data_out", exp, read_data_out);
   endtask
   task automatic ctl(input logic do_rewind);
      while (read_rise_phase !== 1'h1) @(negedge ref_clk);
      if (do_rewind) retransmit_n = 1'h0;
      else mark_read_pos = 1'h1;
      @(negedge ref_clk);
      retransmit_n = 1'h1;
      mark_read_pos = 1'h0;
      @(negedge ref_clk);
   endtask
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 5000) begin
         errors++;
         conclude();
      end
   end
   initial begin
      repeat (16) @(negedge ref_clk);
      rst = 1'h0;
      for (int i = 0; i < 7; i++) begin
         cfg({5'h00, rows[i].sel});
         for (int k = 0; k < rows[i].nw; k++) wr(40'h1 + 40'(k));
         write_valid = 1'h0;
         repeat (4) @(negedge ref_clk);
         chk("almost_empty_n", 40'(rows[i].ae), 40'(almost_empty_n));
         chk("almost_full_n", 40'(rows[i].af), 40'(almost_full_n));
      end
      cfg(7'h00);
      chk("read_data_out", 40'h0, read_data_out);
      for (int k = 0; k < 15; k++) wr(40'hA000000000 | 40'(k));
      write_valid = 1'h0;
      repeat (4) @(negedge ref_clk);
      chk("write_ready", 40'h0, 40'(write_ready));
      chk("almost_full_n", 40'h0, 40'(almost_full_n));
      for (int k = 0; k < 15; k++) rdchk(40'hA000000000 | 40'(k));
      chk("almost_empty_n", 40'h0, 40'(almost_empty_n));
      use_sel = 1'h0;
      repeat (3) @(negedge ref_clk);
      chk("read_data_oe", 40'h0, 40'(read_data_oe));
      hiz_req = 1'h1;
      repeat (3) @(negedge ref_clk);
      hiz_req = 1'h0;
      use_sel = 1'h1;
      repeat (3) @(negedge ref_clk);
      chk("read_data_oe", 40'h1, 40'(read_data_oe));
      cfg(7'h04);
      chk("fall_through_active", 40'h1, 40'(fall_through_active));
      wr(40'h5A5A5A5A5A);
      write_valid = 1'h0;
      repeat (4) @(negedge ref_clk);
      chk("read_data_out", 40'h5A5A5A5A5A, read_data_out);
      chk("status_flag_n", 40'h0, 40'(status_flag_n));
      pointer_only_reset_n = 1'h0;
      repeat (2) @(negedge ref_clk);
      pointer_only_reset_n = 1'h1;
      @(negedge ref_clk);
      chk("read_data_out", 40'h0, read_data_out);
      chk("fall_through_active", 40'h1, 40'(fall_through_active));
      chk("status_flag_n", 40'h1, 40'(status_flag_n));
      cfg(7'h00);
      for (int k = 0; k < 4; k++) wr(40'hC0 + 40'(k));
      write_valid = 1'h0;
      rdchk(40'hC0);
      rdchk(40'hC1);
      ctl(1'h1);
      rdchk(40'hC0);
      rdchk(40'hC1);
      ctl(1'h0);
      rdchk(40'hC2);
      ctl(1'h0);
      ctl(1'h1);
      rdchk(40'hC3);
      cfg(7'h44);
      chk("fall_through_active", 40'h0, 40'(fall_through_active));
      chk("read_ddr_active", 40'h1, 40'(read_ddr_active));
      wr(40'hD0);
      wr(40'hD1);
      write_valid = 1'h0;
      rdchk(40'hD1);
      cfg(7'h20);
      wr(40'h123456789A);
      write_valid = 1'h0;
      rdchk(40'h000006789A);
      rdchk(40'h0000012345);
      cfg(7'h28);
      wr(40'h11111);
      wr(40'h22222);
      write_valid = 1'h0;
      rdchk(40'h2222211111);
      cfg(7'h30);
      wr(40'h123456789A);
      write_valid = 1'h0;
      rdchk(40'h000000009A);
      rdchk(40'h000000019E);
      rdchk(40'h0000000345);
      rdchk(40'h0000000048);
      cfg(7'h38);
      for (int k = 0; k < 4; k++) wr(40'h1 + 40'(k));
      write_valid = 1'h0;
      rdchk(40'h0100300801);
      conclude();
   end
endmodule // ddr_sdr_fifo_read_flag_control_tb
`default_nettype wire
